/* hdl/rsp_pkg.sv */
// package for the reset strap loader and shared status terminals
// assumes one core clock; terminals resolved by the pad ring
package rsp_pkg;
  // strap values sampled at reset release
  typedef struct packed {
    logic busSelect;      // 0 smbus slave, 1 i2c eeprom master
    logic powerPolarity;  // 0 active high, 1 active low
    logic gang;           // 0 per-port, 1 ganged
    logic switchDisable;  // 0 switching, 1 none
    logic chargeSupport;  // port 2 charging support
    logic testMode;
  } rsp_straps_s;

  // link status shown on the terminals after reset
  typedef struct packed {
    logic dn2SuperSpeed;
    logic dn1SuperSpeed;
    logic upHighSpeed;
    logic upSuperSpeed;
  } rsp_status_s;

  // output and enable view of a shared terminal
  typedef struct packed {
    logic o;
    logic oe;
  } rsp_pad_s;

  typedef enum logic {RSP_SMBUS, RSP_I2C} rsp_bus_e;

  localparam int SYNC_STAGES = 3;
  localparam logic [6:0] SMB_ADDR_BASE = 7'h08; // bit 3 fixed at 1
  localparam int SMB_ADDR_BIT1 = 1;
  localparam int SMB_ADDR_BIT2 = 2;
  localparam int NUM_STRAP_PINS = 6;
  localparam logic [5:0] STRAP_RESET = 6'h00;
  // last settle count; capture on the edge after it is reached
  localparam logic [2:0] SETTLE_LAST = 3'h6;
endpackage

/* hdl/rsp_sync.sv */
// three flop synchroniser with second/third agreement filter
// assumes the input is asynchronous to ref_clk
`timescale 1ns/1ns
module rsp_sync
#(
  parameter int WIDTH = 6
)
(
  // clock and reset
  input wire logic refClk,
  input wire logic srst,
  // data
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  import rsp_pkg::*;
  logic [WIDTH-1:0] s1_q, s2_q, s3_q, out_q;
  logic [WIDTH-1:0] out_d;

  always_comb
  begin
    out_d = out_q;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (s2_q[i] == s3_q[i])
        out_d[i] = s2_q[i];
    end
  end

  always_ff @(posedge refClk)
  begin
    if (srst)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end
    else
    begin
      s1_q <= asyncIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign syncOut = out_q;
endmodule // rsp_sync

/* hdl/rsp_strap_loader.sv */
// strap capture at reset release and reuse of the strap terminals
// assumes srst synchronous to ref_clk; pad ring resolves o/oe pairs
// Notes on behaviour
// - bus select strap: 0 smbus, 1 i2c
// - data line serves eeprom or smbus host
// - bus select terminal then shows dn2 superspeed
// - polarity strap: 0 active high, 1 low
// - polarity terminal then shows dn1 superspeed
// - gang strap: 0 per-port, 1 ganged
// - smbus address bit 2 from gang strap
// - gang terminal then shows upstream highspeed
// - switch strap: 0 switching, 1 none
// - smbus address bit 1 from switch strap
// - smbus address bit 3 always one
// - switch terminal then shows upstream superspeed
// - test high at reset enters test mode
// - port 2 power pin sampled: charging support
`timescale 1ns/1ns
module rsp_strap_loader
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // shared strap / status terminals (input side)
  input wire logic bus_select_strap,
  input wire logic power_out_polarity_strap,
  input wire logic slave_addr_bit2_strap,
  input wire logic slave_addr_bit1_strap,
  input wire logic charge_support_strap,
  input wire logic testIn,
  // shared terminals (output side)
  output rsp_pkg::rsp_pad_s dn2Pad,
  output rsp_pkg::rsp_pad_s dn1Pad,
  output rsp_pkg::rsp_pad_s upHsPad,
  output rsp_pkg::rsp_pad_s upSsPad,
  // link status from the hub core
  input rsp_pkg::rsp_status_s linkStatus,
  // port power requests from the hub core, active high
  input wire logic [1:0] portPowerReq,
  output rsp_pkg::rsp_pad_s [1:0] port_power_out,
  // sideband data line routing
  input wire logic sideband_data_line_in,
  input wire logic eepromDataOut,
  input wire logic eepromDataOe,
  input wire logic smbusDataOut,
  input wire logic smbusDataOe,
  output rsp_pkg::rsp_pad_s sideband_data_line,
  output logic eepromDataIn,
  output logic smbusDataIn,
  // decoded configuration
  output rsp_pkg::rsp_straps_s straps,
  output logic [6:0] smbusSlaveAddr,
  output logic strapsValid
);
  import rsp_pkg::*;

  logic [NUM_STRAP_PINS-1:0] pinSync;
  rsp_straps_s straps_q, straps_d;
  logic valid_q, valid_d;
  logic [6:0] addr_q, addr_d;
  rsp_status_s stat_q, stat_d;
  logic [1:0] pwr_q, pwr_d;
  rsp_bus_e busMode;

  rsp_sync #(.WIDTH(NUM_STRAP_PINS)) u_sync
  (
    .refClk(ref_clk),
    .srst(srst),
    .asyncIn({testIn, charge_support_strap, slave_addr_bit1_strap,
              slave_addr_bit2_strap, power_out_polarity_strap,
              bus_select_strap}),
    .syncOut(pinSync)
  );

  // pins must settle through the filter before capture
  // filter output is valid four edges after release; capture at seven
  logic [2:0] settle_q, settle_d;

  always_comb
  begin
    straps_d = straps_q;
    valid_d = valid_q;
    addr_d = addr_q;
    settle_d = settle_q;
    if (!valid_q)
    begin
      if (settle_q != SETTLE_LAST)
        settle_d = settle_q + 3'h1;
      else
      begin
        // single capture after reset release
        valid_d = 1'b1;
        straps_d.busSelect = pinSync[0];
        straps_d.powerPolarity = pinSync[1];
        straps_d.gang = pinSync[2];
        straps_d.switchDisable = pinSync[3];
        straps_d.chargeSupport = pinSync[4];
        straps_d.testMode = pinSync[5];
        addr_d = SMB_ADDR_BASE;
        addr_d[SMB_ADDR_BIT2] = pinSync[2];
        addr_d[SMB_ADDR_BIT1] = pinSync[3];
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      straps_q <= rsp_straps_s'(STRAP_RESET);
      valid_q <= 1'b0;
      addr_q <= SMB_ADDR_BASE;
      settle_q <= 3'h0;
    end
    else
    begin
      straps_q <= straps_d;
      valid_q <= valid_d;
      addr_q <= addr_d;
      settle_q <= settle_d;
    end
  end

  // status and power outputs registered
  // power uses the straps being captured, so the first driven cycle
  // already has the right polarity
  always_comb
  begin
    stat_d = linkStatus;
    pwr_d = 2'h0;
    if (!straps_d.switchDisable)
    begin
      if (straps_d.gang)
        pwr_d = {2{|portPowerReq}};
      else
        pwr_d = portPowerReq;
    end
    pwr_d = pwr_d ^ {2{straps_d.powerPolarity}};
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      stat_q <= '0;
      pwr_q <= 2'h0;
    end
    else
    begin
      stat_q <= stat_d;
      pwr_q <= pwr_d;
    end
  end

  assign dn2Pad = '{o: stat_q.dn2SuperSpeed, oe: valid_q};
  assign dn1Pad = '{o: stat_q.dn1SuperSpeed, oe: valid_q};
  assign upHsPad = '{o: stat_q.upHighSpeed, oe: valid_q};
  assign upSsPad = '{o: stat_q.upSuperSpeed, oe: valid_q};

  // power pins stay released until the charge strap is captured
  assign port_power_out[0] = '{o: pwr_q[0], oe: valid_q};
  assign port_power_out[1] = '{o: pwr_q[1], oe: valid_q};

  // sideband data line goes to one engine only
  assign busMode = straps_q.busSelect ? RSP_I2C : RSP_SMBUS;
  always_comb
  begin
    sideband_data_line = '{o: 1'b0, oe: 1'b0};
    eepromDataIn = 1'b1;
    smbusDataIn = 1'b1;
    if (valid_q)
    begin
      case (busMode)
        RSP_I2C:
        begin
          sideband_data_line = '{o: eepromDataOut, oe: eepromDataOe};
          eepromDataIn = sideband_data_line_in;
        end
        RSP_SMBUS:
        begin
          sideband_data_line = '{o: smbusDataOut, oe: smbusDataOe};
          smbusDataIn = sideband_data_line_in;
        end
        default:
        begin
          sideband_data_line = '{o: 1'b0, oe: 1'b0};
        end
      endcase
    end
  end

  assign straps = straps_q;
  assign smbusSlaveAddr = addr_q;
  assign strapsValid = valid_q;
endmodule // rsp_strap_loader

/* sim/rsp_board_model.sv */
// board side: strap pulls on the shared terminals
// assumes a terminal shows the pad while the device enables it
`timescale 1ns/1ns
module rsp_board_model
(
  // strap settings
  input wire logic [5:0] cfg,
  // device terminals
  input rsp_pkg::rsp_pad_s dn2Pad,
  input rsp_pkg::rsp_pad_s dn1Pad,
  input rsp_pkg::rsp_pad_s upHsPad,
  input rsp_pkg::rsp_pad_s upSsPad,
  input rsp_pkg::rsp_pad_s [1:0] port_power_out,
  input rsp_pkg::rsp_pad_s sideband_data_line,
  // resolved levels
  output logic bus_select_strap,
  output logic power_out_polarity_strap,
  output logic slave_addr_bit2_strap,
  output logic slave_addr_bit1_strap,
  output logic charge_support_strap,
  output logic testIn,
  output logic sideband_data_line_in
);
  import rsp_pkg::*;
  function automatic logic pin(rsp_pad_s p, logic pull);
    return p.oe ? p.o : pull;
  endfunction
  assign bus_select_strap = pin(dn2Pad, cfg[5]);
  assign power_out_polarity_strap = pin(dn1Pad, cfg[4]);
  assign slave_addr_bit2_strap = pin(upHsPad, cfg[3]);
  assign slave_addr_bit1_strap = pin(upSsPad, cfg[2]);
  assign charge_support_strap = pin(port_power_out[1], cfg[1]);
  assign testIn = cfg[0];
  assign sideband_data_line_in = pin(sideband_data_line, 1'b0);
endmodule // rsp_board_model

/* sim/rsp_strap_loader_chk.sv */
// timing relations on the strap loader ports
// assumes one clock, srst synchronous
`timescale 1ns/1ns
module rsp_strap_loader_chk
(
  input wire logic ref_clk,
  input wire logic srst,
  input rsp_pkg::rsp_pad_s dn2Pad,
  input rsp_pkg::rsp_pad_s upSsPad,
  input rsp_pkg::rsp_status_s linkStatus,
  input wire logic [1:0] portPowerReq,
  input rsp_pkg::rsp_pad_s [1:0] port_power_out,
  input wire logic sideband_data_line_in,
  input wire logic smbusDataIn,
  input rsp_pkg::rsp_straps_s straps,
  input wire logic [6:0] smbusSlaveAddr,
  input wire logic strapsValid
);
  import rsp_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  sequence s_held;
    strapsValid ##1 strapsValid;
  endsequence
  a_no_early_drive: assert property (!strapsValid |->
    !dn2Pad.oe && !port_power_out[1].oe) else $error("early drive");
  a_drive_after: assert property (strapsValid |->
    dn2Pad.oe && upSsPad.oe) else $error("pad not driven");
  a_capture_bound: assert property (!strapsValid |->
    ##[1:8] strapsValid) else $error("capture late");
  a_straps_held: assert property (s_held |-> $stable(straps))
    else $error("straps moved");
  a_addr_map: assert property (strapsValid |->
    smbusSlaveAddr == {4'h1, straps.gang, straps.switchDisable, 1'b0})
    else $error("address wrong");
  a_dn2_follow: assert property (s_held |->
    dn2Pad.o == $past(linkStatus.dn2SuperSpeed)) else $error("dn2");
  a_upss_follow: assert property (s_held |->
    upSsPad.o == $past(linkStatus.upSuperSpeed)) else $error("upss");
  a_power_map: assert property (s_held ##0 !straps.switchDisable
    ##0 !straps.gang |-> port_power_out[0].o ==
    ($past(portPowerReq[0]) ^ straps.powerPolarity)) else $error("pwr");
  a_power_off: assert property (s_held ##0 straps.switchDisable |->
    port_power_out[1].o == straps.powerPolarity) else $error("pwr off");
  a_smbus_route: assert property (strapsValid && !straps.busSelect |->
    smbusDataIn == sideband_data_line_in) else $error("route");
endmodule // rsp_strap_loader_chk

/* sim/rsp_strap_loader_tb_top.sv */
// bench: random straps, status and power requests
// assumes the board model resolves the shared terminals
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; \
  $display("ERROR %0t mismatch", $time); end end
module rsp_strap_loader_tb_top;
  import rsp_pkg::*;
  logic ref_clk = 0, srst = 1, eepromDataOut = 0, eepromDataOe = 0;
  logic smbusDataOut = 0, smbusDataOe = 0, eepromDataIn, smbusDataIn;
  logic bus_select_strap, power_out_polarity_strap, testIn;
  logic slave_addr_bit2_strap, slave_addr_bit1_strap;
  logic charge_support_strap, sideband_data_line_in, strapsValid;
  logic [5:0] cfg = '0, exp;
  logic [1:0] portPowerReq = '0;
  logic [15:0] rnd = 16'h2a69;
  logic [5:0] padOe;
  logic [3:0] padO;
  logic [1:0] pwrO, sbPad;
  logic [6:0] smbusSlaveAddr;
  rsp_status_s linkStatus = '0;
  rsp_pad_s dn2Pad, dn1Pad, upHsPad, upSsPad, sideband_data_line;
  rsp_pad_s [1:0] port_power_out;
  rsp_straps_s straps;
  int fails = 0, comparisons = 0, n;
  rsp_strap_loader dut (.*);
  rsp_board_model board (.*);
  assign padOe = {dn2Pad.oe, dn1Pad.oe, upHsPad.oe, upSsPad.oe,
    port_power_out[1].oe, port_power_out[0].oe};
  assign padO = {dn2Pad.o, dn1Pad.o, upHsPad.o, upSsPad.o};
  assign pwrO = {port_power_out[1].o, port_power_out[0].o};
  assign sbPad = sideband_data_line;
  initial forever #5 ref_clk = ~ref_clk;
  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic pw(int i);
    if (exp[2])
      return exp[4];
    return (exp[3] ? |portPowerReq : portPowerReq[i]) ^ exp[4];
  endfunction
  task automatic results;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    for (int t = 0; t < 20; t++)
    begin
      @(negedge ref_clk);
      srst = 1;
      cfg = t < 2 ? {6{t[0]}} : rnd[15:10];
      exp = cfg;
      rnd = lfsr(rnd);
      repeat (8) @(negedge ref_clk);
      `CHK(padOe, 6'h00)
      `CHK(strapsValid, 1'b0)
      srst = 0;
      n = 0;
      while (strapsValid !== 1'b1 && n < 20)
      begin
        @(negedge ref_clk);
        n++;
      end
      if (n == 20)
      begin
        fails++;
        results();
      end
      `CHK(straps, rsp_straps_s'(exp))
      `CHK(smbusSlaveAddr, {4'h1, exp[3], exp[2], 1'b0})
      `CHK(padOe, 6'h3f)
      for (int k = 0; k < 10; k++)
      begin
        {linkStatus, portPowerReq, eepromDataOut, eepromDataOe,
          smbusDataOut, smbusDataOe} = rnd[9:0];
        cfg = rnd[15:10];
        rnd = lfsr(rnd);
        @(negedge ref_clk);
        `CHK(padO, linkStatus)
        `CHK(pwrO, {pw(1), pw(0)})
        `CHK(sbPad[1], exp[5] ? eepromDataOut : smbusDataOut)
        `CHK(sbPad[0], exp[5] ? eepromDataOe : smbusDataOe)
        `CHK(eepromDataIn, exp[5] ? sideband_data_line_in : 1'b1)
        `CHK(smbusDataIn, exp[5] ? 1'b1 : sideband_data_line_in)
        `CHK(straps, rsp_straps_s'(exp))
      end
      $display("test %0d done", t);
    end
    results();
  end
endmodule // rsp_strap_loader_tb_top
bind rsp_strap_loader rsp_strap_loader_chk chk (.*);
